/* File: gated_16bit_timer_control_tb_top.sv */
/*
  Testbench of the gated timer: APB master tasks and scenarios.
  Assumes gtc_timer, gtc_src_model and the bound checker.
*/
module gated_16bit_timer_control_tb_top import gtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ext_run = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  gtc_src_type lvl = '0;
  gtc_src_type src;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er;
  logic [15:0] cnt;
  int bad_count = 0;
  int comparisons = 0;
  always #20 pclk = ~pclk;
  gtc_src_model mdl_u (.pclk(pclk), .ext_run(ext_run), .lvl(lvl), .src(src));
  gtc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
    .irq(irq));
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t no pready", $time);
      final_report();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rg
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rng(input int e);
    comparisons++;
    if ((cnt + 16'd4 >= e && cnt <= e + 2) !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t count %h near %0d", $time, cnt, e);
    end
  endtask : rng
  task automatic run(input logic [7:0] tc);
    wr(ADDR_COUNT_LOW, 32'h0);
    wr(ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_TIMER_CONTROL, {24'h0, tc});
    repeat (64) @(posedge pclk);
    wr(ADDR_TIMER_CONTROL, {24'h0, tc & 8'hFE});
    rg(ADDR_COUNT_LOW);
    cnt[7:0] = rd[7:0];
    rg(ADDR_COUNT_HIGH);
    cnt[15:8] = rd[7:0];
  endtask : run
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_rate();
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        run({s[1:0], p[1:0], 4'h1});
        rng(68 / ((s == 1 ? 1 : 4) << p));
      end
    end
    ext_run <= 1'b1;
    for (int y = 0; y < 2; y++) begin
      run({SRC_PIN, 3'h0, y[0], 2'h1});
      rng(17);
    end
    ext_run <= 1'b0;
    rg(ADDR_COUNT_LOW);
    chk(rd[7:0], cnt[7:0]);
  endtask : t_rate
  task automatic t_gate();
    wr(ADDR_TIMER_CONTROL, 32'h41);
    for (int q = 0; q < 4; q++) begin
      wr(ADDR_GATE_CONTROL, 32'h40 | q);
      lvl <= gtc_src_type'(6'h1 << (3 - q));
      repeat (4) @(posedge pclk);
      rg(ADDR_GATE_CONTROL);
      chk(rd[2], 1'b1);
      lvl <= '0;
      repeat (4) @(posedge pclk);
      rg(ADDR_GATE_CONTROL);
      chk(rd[2], 1'b0);
      rg(ADDR_IRQ_STATUS);
      chk(rd[1], 1'b1);
      wr(ADDR_IRQ_STATUS, 32'h2);
    end
    lvl <= gtc_src_type'(6'h08);
    for (int g = 0; g < 3; g++) begin
      wr(ADDR_GATE_CONTROL, g < 2 ? 32'h80 | (g << 6) : 32'h0);
      run(8'h41);
      rng(g == 0 ? 0 : 68);
    end
  endtask : t_gate
  task automatic t_single();
    lvl <= '0;
    wr(ADDR_GATE_CONTROL, 32'hD8);
    rg(ADDR_GATE_CONTROL);
    chk(rd[3], 1'b1);
    wr(ADDR_COUNT_LOW, 32'h0);
    wr(ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_TIMER_CONTROL, 32'h41);
    for (int k = 0; k < 2; k++) begin
      repeat (4) @(posedge pclk);
      lvl <= gtc_src_type'(6'h08);
      repeat (20) @(posedge pclk);
      lvl <= '0;
    end
    repeat (4) @(posedge pclk);
    wr(ADDR_TIMER_CONTROL, 32'h0);
    rg(ADDR_GATE_CONTROL);
    chk(rd[3], 1'b0);
    rg(ADDR_COUNT_LOW);
    cnt = {8'h0, rd[7:0]};
    rng(21);
    wr(ADDR_GATE_CONTROL, 32'h0);
  endtask : t_single
  task automatic t_toggle();
    lvl <= '0;
    wr(ADDR_GATE_CONTROL, 32'hE0);
    wr(ADDR_COUNT_LOW, 32'h0);
    wr(ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_TIMER_CONTROL, 32'h41);
    for (int k = 0; k < 4; k++) begin
      lvl <= k[0] ? gtc_src_type'(6'h00) : gtc_src_type'(6'h08);
      repeat (10) @(posedge pclk);
    end
    repeat (20) @(posedge pclk);
    wr(ADDR_TIMER_CONTROL, 32'h0);
    rg(ADDR_COUNT_LOW);
    cnt = {8'h0, rd[7:0]};
    rng(20);
    rg(ADDR_GATE_CONTROL);
    chk(rd[2], 1'b0);
    wr(ADDR_GATE_CONTROL, 32'h0);
  endtask : t_toggle
  task automatic t_ovf();
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_COUNT_LOW, 32'hF0);
    wr(ADDR_COUNT_HIGH, 32'hFF);
    wr(ADDR_TIMER_CONTROL, 32'h41);
    repeat (40) @(posedge pclk);
    wr(ADDR_TIMER_CONTROL, 32'h0);
    chk(irq, 1'b1);
    rg(ADDR_IRQ_STATUS);
    chk(rd[0], 1'b1);
    rg(ADDR_COUNT_LOW);
    cnt = {8'h0, rd[7:0]};
    rng(28);
    wr(ADDR_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0);
  endtask : t_ovf
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rg(ADDR_GATE_CONTROL);
    chk(rd & 32'hFFFFFFFB, 32'h0);
    rg(8'h18);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    t_rate();
    t_gate();
    t_single();
    t_toggle();
    t_ovf();
    final_report();
  end
endmodule : gated_16bit_timer_control_tb_top

/* File: gtc_pkg.sv */
/*
  Constants, register map and carrier types of the gated 16-bit timer.
  Assumes an APB slave with 32-bit data and one register per aligned word.
*/
// What this block does
// - Two-bit prescale: 11 is 1:8, 10 is 1:4, 01 is 1:2, 00 is 1:1.
// - Sync bypass set leaves ext clock unsynchronised; clear synchronises it.
// - Gate enable ignored when off; when on, counting follows the gate.
// - Gate polarity 1 counts while gate high; 0 counts while gate low.
// - Toggle mode routes gate through a toggling flop; clear holds it clear.
// - Single pulse mode lets acquisition logic control the gate.
// - Software sets go bit to arm; hardware clears it when done.
// - Go bit clears on trailing gate edge; further increments blocked.
// - Read-only gate level status, valid regardless of gate enable.
// - Gate source: 11 comparator two, 10 comparator one, 01 overflow, 00 pin.
// - Falling edge of gate level status sets gate event flag always.
// - Count rolls FFFFh to 0000h and sets the overflow flag.
package gtc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GATE_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TC_SRC_LSB = 6;
  localparam int TC_PRE_LSB = 4;
  localparam int TC_SYNC_BIT = 2;
  localparam int TC_ON_BIT = 0;
  localparam int GC_EN_BIT = 7;
  localparam int GC_POL_BIT = 6;
  localparam int GC_TM_BIT = 5;
  localparam int GC_SPM_BIT = 4;
  localparam int GC_GO_BIT = 3;
  localparam int GC_VAL_BIT = 2;
  localparam int GC_SS_LSB = 0;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_GATE_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] TC_RESET = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h00;
  localparam logic [7:0] TC_WMASK = 8'hF5;
  localparam logic [7:0] GC_WMASK = 8'hFB;
  localparam logic [1:0] SRC_LFOSC = 2'h3;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam logic [1:0] SRC_SYS = 2'h1;
  localparam logic [1:0] SRC_SYS4 = 2'h0;
  localparam logic [1:0] GSS_CMP2 = 2'h3;
  localparam logic [1:0] GSS_CMP1 = 2'h2;
  localparam logic [1:0] GSS_OVF = 2'h1;
  localparam logic [1:0] GSS_PIN = 2'h0;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic low_freq_internal_osc;
    logic external_clock_pin;
    logic gate_input_pin;
    logic byte_timer_overflow;
    logic comparator_one_out;
    logic comparator_two_out;
  } gtc_src_type;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_WAIT = 2'b01,
    SP_PULSE = 2'b10
  } gtc_sp_type;

endpackage : gtc_pkg

/* File: gtc_prescaler.sv */
/*
  Selects the counting clock source and divides its edges by the prescale.
  Assumes inputs other than the external clock pin are synchronous to pclk; emits one-cycle tick pulses.
*/
module gtc_prescaler
  import gtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] input_prescale_select,
  input wire logic sync_bypass,
  input wire logic run,
  input wire gtc_src_type src,
  output logic tick
);

  typedef struct packed {
    logic [1:0] sys_div;
    logic [2:0] pre_cnt;
    logic ext_s1;
    logic ext_s2;
    logic osc_d;
    logic ext_d;
    logic tick;
  } gtc_pre_state_type;

  gtc_pre_state_type st;
  gtc_pre_state_type next_st;
  logic edge_in;
  logic [2:0] pre_last;

  // ---------------------------------------------------------------
  // Source edge and prescale
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ext_s1 = src.external_clock_pin;
    next_st.ext_s2 = st.ext_s1;
    next_st.osc_d = src.low_freq_internal_osc;
    // Synchronised or direct external clock
    next_st.ext_d = sync_bypass ? src.external_clock_pin : st.ext_s2;
    next_st.sys_div = st.sys_div + 2'h1;
    case (clock_source_select)
      SRC_LFOSC: edge_in = src.low_freq_internal_osc & ~st.osc_d;
      SRC_PIN: edge_in = sync_bypass ?
                 (src.external_clock_pin & ~st.ext_d) :
                 (st.ext_s2 & ~st.ext_d);
      SRC_SYS: edge_in = 1'b1;
      default: edge_in = (st.sys_div == 2'h3);
    endcase
    pre_last = (3'h1 << input_prescale_select) - 3'h1;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.pre_cnt = 3'h0;
    end else if (edge_in) begin
      if (st.pre_cnt >= pre_last) begin
        next_st.pre_cnt = 3'h0;
        next_st.tick = 1'b1;
      end else begin
        next_st.pre_cnt = st.pre_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : gtc_prescaler

/* File: gtc_src_model.sv */
/*
  Far side model: gate, comparator and overflow levels, external clock.
  Assumes the bench sets levels; clock pin stands low unless run.
*/
module gtc_src_model
  import gtc_pkg::*;
(
  input wire logic pclk,
  input wire logic ext_run,
  input wire gtc_src_type lvl,
  output gtc_src_type src
);
  logic [1:0] ph;
  always_ff @(posedge pclk) begin
    ph <= ext_run ? ph + 2'h1 : 2'h0;
  end
  always_comb begin
    src = lvl;
    src.external_clock_pin = ph[1];
  end
endmodule : gtc_src_model

/* File: gtc_timer.sv */
/*
  Gated 16-bit timer with APB register access and one interrupt line.
  Assumes APB3 master on pclk; source inputs synchronous to pclk.
*/
module gtc_timer
  import gtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gtc_src_type src,
  output logic irq
);

  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] gate_control;
    logic [15:0] count;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic toggle_ff;
    logic gpol_d;
    logic gate_val;
    gtc_sp_type sp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } gtc_state_type;

  gtc_state_type st;
  gtc_state_type next_st;
  logic tick;
  logic run;
  logic gsrc;
  logic gpol;
  logic gate_now;
  logic gate_ok;
  logic access;
  logic wr;
  logic rd;
  logic [1:0] ev;

  assign run = st.timer_control[TC_ON_BIT];

  // ---------------------------------------------------------------
  // Clock selection and prescaler
  // ---------------------------------------------------------------
  gtc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_select(st.timer_control[TC_SRC_LSB +: 2]),
    .input_prescale_select(st.timer_control[TC_PRE_LSB +: 2]),
    .sync_bypass(st.timer_control[TC_SYNC_BIT]),
    .run(run),
    .src(src),
    .tick(tick)
  );

  function automatic logic [31:0] rd_mux(input gtc_state_type s,
                                         input logic [7:0] a);
    case (a)
      ADDR_TIMER_CONTROL: rd_mux = {24'h000000, s.timer_control};
      ADDR_GATE_CONTROL: rd_mux = {24'h000000, s.gate_control};
      ADDR_COUNT_LOW: rd_mux = {24'h000000, s.count[7:0]};
      ADDR_COUNT_HIGH: rd_mux = {24'h000000, s.count[15:8]};
      ADDR_IRQ_STATUS: rd_mux = {30'h0, s.irq_status};
      ADDR_IRQ_MASK: rd_mux = {30'h0, s.irq_mask};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction : rd_mux

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_TIMER_CONTROL) || (a == ADDR_GATE_CONTROL) ||
              (a == ADDR_COUNT_LOW) || (a == ADDR_COUNT_HIGH) ||
              (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
  endfunction : addr_ok

  // ---------------------------------------------------------------
  // Gate path, counter, bus
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    ev = 2'b00;
    case (st.gate_control[GC_SS_LSB +: 2])
      GSS_CMP2: gsrc = src.comparator_two_out;
      GSS_CMP1: gsrc = src.comparator_one_out;
      GSS_OVF: gsrc = src.byte_timer_overflow;
      default: gsrc = src.gate_input_pin;
    endcase
    gpol = st.gate_control[GC_POL_BIT] ? gsrc : ~gsrc;
    // Toggle flop steps on rising gate edges while counting
    if (!run || !st.gate_control[GC_TM_BIT]) begin
      next_st.toggle_ff = 1'b0;
    end else if (gpol && !st.gpol_d) begin
      next_st.toggle_ff = ~st.toggle_ff;
    end
    next_st.gpol_d = gpol;
    gate_now = st.gate_control[GC_TM_BIT] ? st.toggle_ff : gpol;
    // Single pulse acquisition
    gate_ok = gate_now;
    if (st.gate_control[GC_SPM_BIT]) begin
      gate_ok = gate_now && (st.sp == SP_PULSE);
    end
    next_st.gate_val = st.gate_control[GC_SPM_BIT] ? gate_ok : gate_now;
    if (st.gate_val && !next_st.gate_val) begin
      ev[IRQ_GATE_BIT] = 1'b1;
    end
    case (st.sp)
      SP_IDLE: begin
        if (st.gate_control[GC_SPM_BIT] && st.gate_control[GC_GO_BIT]) begin
          next_st.sp = gate_now ? SP_IDLE : SP_WAIT;
        end
      end
      SP_WAIT: begin
        if (!st.gate_control[GC_GO_BIT] || !st.gate_control[GC_SPM_BIT]) begin
          next_st.sp = SP_IDLE;
        end else if (gate_now) begin
          next_st.sp = SP_PULSE;
        end
      end
      SP_PULSE: begin
        if (!gate_now || !st.gate_control[GC_SPM_BIT]) begin
          next_st.sp = SP_IDLE;
          next_st.gate_control[GC_GO_BIT] = 1'b0;
        end
      end
      default: next_st.sp = SP_IDLE;
    endcase
    next_st.gate_control[GC_VAL_BIT] = next_st.gate_val;
    // Count on tick, gated when enabled
    if (tick && run && (!st.gate_control[GC_EN_BIT] || gate_ok)) begin
      next_st.count = st.count + 16'h0001;
      if (st.count == COUNT_MAX) begin
        ev[IRQ_OVF_BIT] = 1'b1;
      end
    end
    // APB slave: one wait state in every access phase
    access = psel && penable && !st.pready;
    wr = access && pwrite && addr_ok(paddr);
    rd = access && !pwrite;
    next_st.pready = access;
    next_st.pslverr = access && !addr_ok(paddr);
    if (rd) begin
      next_st.prdata = rd_mux(st, paddr);
    end
    next_st.irq_status = st.irq_status & ~((wr && paddr == ADDR_IRQ_STATUS)
                         ? pwdata[1:0] : 2'b00);
    if (wr) begin
      case (paddr)
        ADDR_TIMER_CONTROL: next_st.timer_control = pwdata[7:0] & TC_WMASK;
        ADDR_GATE_CONTROL: begin
          // Go bit written by software arms acquisition
          next_st.gate_control = (pwdata[7:0] & GC_WMASK) |
                                 {5'h00, next_st.gate_val, 2'h0};
          if (!pwdata[GC_SPM_BIT]) begin
            next_st.sp = SP_IDLE;
          end
        end
        ADDR_COUNT_LOW: next_st.count[7:0] = pwdata[7:0];
        ADDR_COUNT_HIGH: next_st.count[15:8] = pwdata[7:0];
        ADDR_IRQ_MASK: next_st.irq_mask = pwdata[1:0];
        default: ;
      endcase
    end
    next_st.irq_status = next_st.irq_status | ev; // set beats clear
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;

endmodule : gtc_timer

/* File: gtc_timer_sva.sv */
/*
  Port checker of the gated timer: APB answer timing and read values.
  Assumes binding to gtc_timer; sees only its ports.
*/
module gtc_timer_sva
  import gtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic tk = psel && penable && !pready;
  property p_ans; tk |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_cause; pready |-> $past(tk); endproperty
  a_cause: assert property (p_cause) else $error("stray ready");
  property p_err; tk && paddr > 8'h14 && !pwrite |=>
    pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped read");
  property p_ok; tk && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("bad error");
  property p_tc; tk && !pwrite && paddr == ADDR_TIMER_CONTROL |=>
    prdata[31:8] == 24'h0 && !prdata[3] && !prdata[1]; endproperty
  a_tc: assert property (p_tc) else $error("reserved set");
  property p_gc; tk && !pwrite && paddr == ADDR_GATE_CONTROL |=>
    prdata[31:8] == 24'h0; endproperty
  a_gc: assert property (p_gc) else $error("gate width");
  property p_mask; tk && pwrite && paddr == ADDR_IRQ_MASK &&
    pwdata[1:0] == 2'h0 |=> ##[1:2] !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
endmodule : gtc_timer_sva

bind gtc_timer gtc_timer_sva chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));
